// *** src/rail_cfg_pkg.sv ***
package rail_cfg_pkg;

  // Command codes
  localparam logic [7:0] CMD_RAIL_SHARE = 8'hd3;
  localparam logic [7:0] CMD_OK_DELAY   = 8'hd4;
  localparam logic [7:0] CMD_LOOP_TUNE  = 8'hd5;
  localparam logic [7:0] CMD_INDUCTOR   = 8'hd6;

  // Reset values
  localparam logic [15:0] OK_DELAY_RST  = 16'hba00;
  localparam logic [15:0] LOOP_TUNE_RST = 16'h2064;
  localparam logic [15:0] INDUCTOR_RST  = 16'haa66;
  localparam logic [2:0]  PHASE_ID_RST  = 3'h0;
  localparam logic [2:0]  PHASES_RST    = 3'h0;

  // Writable bit masks
  localparam logic [15:0] RAIL_SHARE_MASK = 16'hff07;
  localparam logic [15:0] LOOP_TUNE_MASK  = 16'h3fff;

  // Field positions
  localparam int PHASE_ID_LSB = 13;
  localparam int RAIL_ID_LSB  = 8;
  localparam int PHASES_LSB   = 0;
  localparam int GAIN_SEL_LSB = 12;
  localparam int THRESH_LSB   = 0;
  localparam int EXP_LSB      = 11;
  localparam int ADDR_BITS_KEPT = 5;

  // Fixed point of decoded values
  localparam int FRAC_BITS = 10;
  localparam int Q_W       = 18;
  localparam logic [Q_W-1:0] OK_DELAY_MAX_Q = 18'h1f400;
  localparam logic [Q_W-1:0] INDUCTOR_MAX_Q = 18'h19000;

  // Delay prescaler: one tick is 1/1024 ms
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_PS       = 976563;
  localparam int TICK_CYCLES   = (TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TICK_W        = 8;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // Phase offset in 1/256 of a switching cycle
  localparam int PHASE_W = 8;

  typedef struct packed {
    logic [2:0] phase_id;
    logic [4:0] rail_id;
    logic [4:0] unused;
    logic [2:0] phases_m1;
  } rail_fields_t;

  typedef struct packed {
    logic [1:0]  unused;
    logic [1:0]  gain_sel;
    logic [11:0] threshold;
  } loop_fields_t;

  typedef struct packed {
    logic           neg;
    logic           zero;
    logic           ovf;
    logic [Q_W-1:0] mag;
  } lin_dec_t;

  typedef enum logic [1:0] {OK_LOW, OK_WAIT, OK_HIGH} ok_state_t;

endpackage

// *** src/linear11_decode.sv ***
module linear11_decode
  import rail_cfg_pkg::*;
(
  input  wire logic [15:0] code,
  output lin_dec_t         dec
);

  logic signed [4:0]  exp_n;
  logic signed [10:0] mant_y;
  logic signed [6:0]  shift_s;
  logic [39:0]        wide;

  always_comb begin
    exp_n   = code[15:EXP_LSB];
    mant_y  = code[EXP_LSB-1:0];
    shift_s = 7'(exp_n) + 7'(FRAC_BITS);
    wide    = 40'h0;
    if (shift_s >= 0) begin
      wide = 40'(mant_y[9:0]) << shift_s;
    end else begin
      wide = 40'(mant_y[9:0]) >> (-shift_s);
    end
    dec.neg  = mant_y[10];
    dec.zero = (mant_y == 11'sh0);
    dec.ovf  = (wide[39:Q_W] != 22'h0);
    dec.mag  = wide[Q_W-1:0];
  end

endmodule

// *** src/rail_config_registers.sv ***
module rail_config_registers
  import rail_cfg_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [7:0]   cmd_code,
  input  wire logic         wr_en,
  input  wire logic [15:0]  wr_data,
  input  wire logic         rd_en,
  output logic [15:0]       rd_data,
  output logic              rd_valid,
  output logic              wr_refused,
  output logic              cmd_unmapped,
  input  wire logic [6:0]   strap_addr,
  input  wire logic         vout_above_on,
  input  wire logic [11:0]  vout_error,
  input  wire logic [15:0]  loop_gain_in,
  output logic [15:0]       adaptive_loop_gain,
  output logic              steady_state,
  output logic              output_ok_pin,
  output rail_fields_t      rail_info,
  output logic [PHASE_W-1:0] phase_offset,
  output logic [Q_W-1:0]    inductor_q
);

  function automatic logic [1:0] gain_shift(input logic [1:0] sel);
    case (sel)
      2'h0:    gain_shift = 2'h0;
      2'h1:    gain_shift = 2'h1;
      2'h2:    gain_shift = 2'h2;
      default: gain_shift = 2'h3;
    endcase
  endfunction

  // Pin synchronisers
  logic [6:0] addr_sync1, addr_sync2;
  logic       above_sync1, above_sync2;

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      addr_sync1  <= strap_addr;
      addr_sync2  <= addr_sync1;
      above_sync1 <= vout_above_on;
      above_sync2 <= above_sync1;
    end
  end

  // Register file
  rail_fields_t   rail_reg, rail_next;
  logic [15:0]    ok_delay_reg, ok_delay_next;
  loop_fields_t   loop_reg, loop_next;
  logic [15:0]    inductor_reg, inductor_next;
  logic [15:0]    rd_data_reg, rd_data_next;
  logic           rd_valid_reg, rd_valid_next;
  logic           refused_reg, refused_next;
  logic           unmapped_reg, unmapped_next;
  logic           dly_bad, ind_bad, hit;

  // Linear-11 decoders
  lin_dec_t dec_wr, dec_dly, dec_ind;

  linear11_decode u_dec_wr  (.code(wr_data),      .dec(dec_wr));
  linear11_decode u_dec_dly (.code(ok_delay_reg), .dec(dec_dly));
  linear11_decode u_dec_ind (.code(inductor_reg), .dec(dec_ind));

  always_comb begin
    rail_next     = rail_reg;
    ok_delay_next = ok_delay_reg;
    loop_next     = loop_reg;
    inductor_next = inductor_reg;
    refused_next  = 1'b0;
    unmapped_next = 1'b0;
    rd_valid_next = 1'b0;
    rd_data_next  = rd_data_reg;
    dly_bad = dec_wr.neg || dec_wr.ovf || (dec_wr.mag > OK_DELAY_MAX_Q);
    ind_bad = dec_wr.neg || dec_wr.zero || dec_wr.ovf
              || (dec_wr.mag > INDUCTOR_MAX_Q);
    hit = (cmd_code == CMD_RAIL_SHARE) || (cmd_code == CMD_OK_DELAY)
          || (cmd_code == CMD_LOOP_TUNE) || (cmd_code == CMD_INDUCTOR);
    if (rst) begin
      rail_next.phase_id  = PHASE_ID_RST;
      rail_next.rail_id   = addr_sync2[ADDR_BITS_KEPT-1:0];
      rail_next.unused    = 5'h0;
      rail_next.phases_m1 = PHASES_RST;
      ok_delay_next = OK_DELAY_RST;
      loop_next     = LOOP_TUNE_RST;
      inductor_next = INDUCTOR_RST;
      rd_data_next  = 16'h0;
    end else begin
      if (wr_en) begin
        case (cmd_code)
          CMD_RAIL_SHARE: rail_next = wr_data & RAIL_SHARE_MASK;
          CMD_OK_DELAY: begin
            if (dly_bad) begin
              refused_next = 1'b1;
            end else begin
              ok_delay_next = wr_data;
            end
          end
          CMD_LOOP_TUNE: loop_next = wr_data & LOOP_TUNE_MASK;
          CMD_INDUCTOR: begin
            if (ind_bad) begin
              refused_next = 1'b1;
            end else begin
              inductor_next = wr_data;
            end
          end
          default: unmapped_next = 1'b1;
        endcase
      end
      if (rd_en) begin
        rd_valid_next = 1'b1;
        unmapped_next = unmapped_next || !hit;
        case (cmd_code)
          CMD_RAIL_SHARE: rd_data_next = rail_reg;
          CMD_OK_DELAY:   rd_data_next = ok_delay_reg;
          CMD_LOOP_TUNE:  rd_data_next = loop_reg;
          CMD_INDUCTOR:   rd_data_next = inductor_reg;
          default:        rd_data_next = 16'h0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      rail_reg     <= rail_next;
      ok_delay_reg <= ok_delay_next;
      loop_reg     <= loop_next;
      inductor_reg <= inductor_next;
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      refused_reg  <= refused_next;
      unmapped_reg <= unmapped_next;
    end
  end

  // Rail role, phase spacing, loop gain, inductor
  logic [PHASE_W-1:0] phase_reg, phase_next;
  logic [15:0]        gain_reg, gain_next;
  logic               steady_reg, steady_next;
  logic [Q_W-1:0]     ind_q_reg, ind_q_next;
  logic               steady_now;
  logic [10:0]        phase_num;
  logic [3:0]         phase_cnt;

  always_comb begin
    phase_num  = {rail_reg.phase_id, 8'h0};
    phase_cnt  = {1'b0, rail_reg.phases_m1} + 4'h1;
    steady_now = (vout_error < loop_reg.threshold);
    if (rst) begin
      phase_next  = '0;
      gain_next   = 16'h0;
      steady_next = 1'b0;
      ind_q_next  = '0;
    end else begin
      phase_next  = PHASE_W'(phase_num / 11'(phase_cnt));
      steady_next = steady_now;
      gain_next   = steady_now
                    ? (loop_gain_in >> gain_shift(loop_reg.gain_sel))
                    : loop_gain_in;
      ind_q_next  = dec_ind.mag;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      phase_reg  <= phase_next;
      gain_reg   <= gain_next;
      steady_reg <= steady_next;
      ind_q_reg  <= ind_q_next;
    end
  end

  // Output-ok delay timer
  ok_state_t          ok_state, ok_state_next;
  logic [TICK_W-1:0]  tick_cnt, tick_next;
  logic [Q_W-1:0]     left_reg, left_next;
  logic               ok_pin_reg, ok_pin_next;

  always_comb begin
    ok_state_next = ok_state;
    tick_next     = tick_cnt;
    left_next     = left_reg;
    ok_pin_next   = ok_pin_reg;
    if (rst) begin
      ok_state_next = OK_LOW;
      tick_next     = '0;
      left_next     = '0;
      ok_pin_next   = 1'b0;
    end else begin
      case (ok_state)
        OK_LOW: begin
          tick_next = '0;
          if (above_sync2) begin
            left_next = dec_dly.mag;
            if (dec_dly.mag == '0) begin
              ok_state_next = OK_HIGH;
              ok_pin_next   = 1'b1;
            end else begin
              ok_state_next = OK_WAIT;
            end
          end
        end
        OK_WAIT: begin
          if (!above_sync2) begin
            ok_state_next = OK_LOW;
          end else if (tick_cnt == TICK_LAST) begin
            tick_next = '0;
            left_next = left_reg - 18'h1;
            if (left_reg == 18'h1) begin
              ok_state_next = OK_HIGH;
              ok_pin_next   = 1'b1;
            end
          end else begin
            tick_next = tick_cnt + 8'h1;
          end
        end
        OK_HIGH: begin
          if (!above_sync2) begin
            ok_state_next = OK_LOW;
            ok_pin_next   = 1'b0;
          end
        end
        default: begin
          ok_state_next = OK_LOW;
          ok_pin_next   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      ok_state   <= ok_state_next;
      tick_cnt   <= tick_next;
      left_reg   <= left_next;
      ok_pin_reg <= ok_pin_next;
    end
  end

  assign rd_data            = rd_data_reg;
  assign rd_valid           = rd_valid_reg;
  assign wr_refused         = refused_reg;
  assign cmd_unmapped       = unmapped_reg;
  assign adaptive_loop_gain = gain_reg;
  assign steady_state       = steady_reg;
  assign output_ok_pin      = ok_pin_reg;
  assign rail_info          = rail_reg;
  assign phase_offset       = phase_reg;
  assign inductor_q         = ind_q_reg;

  // Checks
  a_rail_strap_reset: assert property (@(posedge sys_clk)
    rst && ce |=> rail_reg == {3'h0, $past(addr_sync2[4:0]), 8'h0})
    else $error("rail config reset value wrong");
  a_delay_reset_val: assert property (@(posedge sys_clk)
    rst && ce |=> ok_delay_reg == OK_DELAY_RST && loop_reg == LOOP_TUNE_RST)
    else $error("delay or loop reset value wrong");
  a_ind_reset_val: assert property (@(posedge sys_clk)
    rst && ce |=> inductor_reg == INDUCTOR_RST)
    else $error("inductor reset value wrong");
  a_delay_refuse_keep: assert property (@(posedge sys_clk) disable iff (rst)
    ce && wr_en && cmd_code == CMD_OK_DELAY && dly_bad
    |=> wr_refused && $stable(ok_delay_reg))
    else $error("bad delay not refused");
  a_ind_range_keep: assert property (@(posedge sys_clk) disable iff (rst)
    ce && wr_en && cmd_code == CMD_INDUCTOR && !ind_bad
    |=> inductor_reg == $past(wr_data) && !wr_refused)
    else $error("good inductor not stored");
  a_unused_bits_zero: assert property (@(posedge sys_clk) disable iff (rst)
    rail_reg.unused == 5'h0 && loop_reg.unused == 2'h0)
    else $error("unused bits not zero");
  a_gain_steady_div: assert property (@(posedge sys_clk) disable iff (rst)
    ce && steady_now ##1 ce |-> adaptive_loop_gain
      == ($past(loop_gain_in) >> gain_shift($past(loop_reg.gain_sel))))
    else $error("steady gain not divided");
  a_gain_full_out: assert property (@(posedge sys_clk) disable iff (rst)
    ce && !steady_now |=> adaptive_loop_gain == $past(loop_gain_in))
    else $error("gain divided outside steady state");
  a_ok_not_early: assert property (@(posedge sys_clk) disable iff (rst)
    ok_state == OK_LOW && above_sync2 && ce && dec_dly.mag != '0
    |=> !output_ok_pin [*2])
    else $error("output ok asserted before delay");
  a_ok_zero_delay: assert property (@(posedge sys_clk) disable iff (rst)
    ok_state == OK_LOW && above_sync2 && ce && dec_dly.mag == '0
    |=> output_ok_pin)
    else $error("zero delay not immediate");
  a_phase_half_turn: assert property (@(posedge sys_clk) disable iff (rst)
    ce && rail_reg.phases_m1 == 3'h1 && rail_reg.phase_id == 3'h1
    |=> phase_offset == 8'h80)
    else $error("two-phase offset not 180 degrees");

  c_delay_refused: cover property (@(posedge sys_clk) wr_refused);
  c_ok_asserted: cover property (@(posedge sys_clk)
    ok_state == OK_WAIT ##1 output_ok_pin);
  c_steady_gain: cover property (@(posedge sys_clk)
    steady_state && loop_reg.gain_sel == 2'h3);

endmodule

// *** dv/pmbus_host_model.sv ***
module pmbus_host_model
  import rail_cfg_pkg::*;
(
  input  wire logic        sys_clk,
  output logic [7:0]       cmd_code,
  output logic             wr_en,
  output logic [15:0]      wr_data,
  output logic             rd_en,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        wr_refused,
  input  wire logic        cmd_unmapped
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cmd_code = 8'h00;
    wr_en    = 1'b0;
    wr_data  = 16'h0000;
    rd_en    = 1'b0;
  end

  // One command access; idle gaps make the host prompt or slow
  task automatic access(input  logic [7:0]  c,
                        input  logic        wr,
                        input  logic [15:0] dat,
                        output logic [17:0] q,
                        output logic [2:0]  fl);
    int gap;
    gap = $urandom_range(2);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    cmd_code <= c;
    wr_data  <= dat;
    wr_en    <= wr;
    rd_en    <= !wr;
    @(posedge sys_clk);
    wr_en    <= 1'b0;
    rd_en    <= 1'b0;
    wr_data  <= ~dat;
    cmd_code <= ~c;
    @(posedge sys_clk);
    q  = {2'b00, rd_data};
    fl = {rd_valid, cmd_unmapped, wr_refused};
  endtask
endmodule

// *** dv/tb_top.sv ***
module tb_top
  import rail_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic               sys_clk, rst, ce, wr_en, rd_en, st;
  logic               rd_valid, wr_refused, cmd_unmapped;
  logic               vout_above_on, steady_state, output_ok_pin;
  logic [7:0]         cmd_code;
  logic [15:0]        wr_data, rd_data, loop_gain_in, adaptive_loop_gain, d;
  logic [6:0]         strap_addr, a;
  logic [11:0]        vout_error;
  rail_fields_t       rail_info;
  logic [PHASE_W-1:0] phase_offset;
  logic [Q_W-1:0]     inductor_q;
  logic [17:0]        q;
  logic [2:0]         fl;
  logic [15:0]        keep [2] = '{16'hba00, 16'haa66};
  logic [24:0]        tbl [10] = '{25'h1d4007d, 25'h0d4007e, 25'h0d407ff,
                                   25'h0d4083f, 25'h1d4b002, 25'h0d60065,
                                   25'h0d60000, 25'h0d607ff, 25'h0d60864,
                                   25'h1d60064};
  int                 bad_count, cmp_count, n;

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  rail_config_registers dut (.sys_clk, .rst, .ce, .cmd_code, .wr_en,
    .wr_data, .rd_en, .rd_data, .rd_valid, .wr_refused, .cmd_unmapped,
    .strap_addr, .vout_above_on, .vout_error, .loop_gain_in,
    .adaptive_loop_gain, .steady_state, .output_ok_pin, .rail_info,
    .phase_offset, .inductor_q);

  pmbus_host_model host (.sys_clk, .cmd_code, .wr_en, .wr_data, .rd_en,
    .rd_data, .rd_valid, .wr_refused, .cmd_unmapped);

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    host.access(c, 1'b1, v, q, fl);
  endtask

  task automatic rd(input logic [7:0] c);
    host.access(c, 1'b0, 16'h0000, q, fl);
  endtask

  function automatic logic [17:0] exp_phase(input logic [15:0] v);
    return 18'(8'((32'(v[15:13]) * 256) / (32'(v[2:0]) + 1)));
  endfunction

  task automatic do_reset(input logic [6:0] adr);
    @(posedge sys_clk);
    strap_addr <= adr;
    rst        <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  task automatic chk_defaults(input logic [6:0] adr);
    rd(CMD_RAIL_SHARE);
    chk(q, {5'h00, adr[4:0], 8'h00});
    chk(18'(fl[2]), 18'h1);
    rd(CMD_OK_DELAY);
    chk(q, 18'(OK_DELAY_RST));
    rd(CMD_LOOP_TUNE);
    chk(q, 18'(LOOP_TUNE_RST));
    rd(CMD_INDUCTOR);
    chk(q, 18'(INDUCTOR_RST));
    chk(18'(inductor_q), 18'd307);
  endtask

  initial begin
    void'($urandom(34));
    rst           = 1'b1;
    ce            = 1'b1;
    strap_addr    = 7'h00;
    vout_above_on = 1'b0;
    vout_error    = 12'h000;
    loop_gain_in  = 16'h0000;
    a = 7'($urandom);
    do_reset(a);
    chk_defaults(a);
    // Rail identity, all-ones first
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 16'hffff : 16'($urandom);
      wr(CMD_RAIL_SHARE, d);
      rd(CMD_RAIL_SHARE);
      chk(q, 18'(d & RAIL_SHARE_MASK));
      chk(18'(rail_info), 18'(d & RAIL_SHARE_MASK));
      chk(18'(phase_offset), exp_phase(d));
    end
    // Every divisor, thresholds at the edges
    for (int g = 0; g < 4; g++) begin
      d = {2'b11, 2'(g), (g == 0) ? 12'h000 : 12'($urandom)};
      wr(CMD_LOOP_TUNE, d);
      rd(CMD_LOOP_TUNE);
      chk(q, 18'(d & LOOP_TUNE_MASK));
      for (int k = 0; k < 6; k++) begin
        @(posedge sys_clk);
        vout_error   <= (k == 0) ? d[11:0] :
                        (k == 1) ? d[11:0] - 12'h001 : 12'($urandom);
        loop_gain_in <= 16'($urandom);
        repeat (2) @(posedge sys_clk);
        #1;
        st = vout_error < d[11:0];
        chk(18'(steady_state), 18'(st));
        chk(18'(adaptive_loop_gain),
            18'(st ? loop_gain_in >> g : loop_gain_in));
      end
    end
    // Range limits of delay and inductor
    foreach (tbl[i]) begin
      wr(tbl[i][23:16], tbl[i][15:0]);
      chk(18'(fl[0]), 18'(!tbl[i][24]));
      if (tbl[i][24])
        keep[tbl[i][17]] = tbl[i][15:0];
      rd(tbl[i][23:16]);
      chk(q, 18'(keep[tbl[i][17]]));
    end
    chk(18'(inductor_q), 18'h19000);
    rd(8'hd7);
    chk(18'(fl[1]), 18'h1);
    chk(q, 18'h0);
    // Output ok after 2/1024 ms
    @(posedge sys_clk);
    vout_above_on <= 1'b1;
    n = 0;
    while (output_ok_pin !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    chk(18'(n >= 392 && n <= 410), 18'h1);
    vout_above_on <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk(18'(output_ok_pin), 18'h0);
    wr(CMD_OK_DELAY, 16'h0000);
    @(posedge sys_clk);
    vout_above_on <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(18'(output_ok_pin), 18'h1);
    vout_above_on <= 1'b0;
    // Second reset in mid-run with a new strap
    a = 7'($urandom);
    do_reset(a);
    chk_defaults(a);
    final_report();
  end

  initial begin
    #100us;
    bad_count++;
    final_report();
  end
endmodule
